// >>> verilog/chpm_pkg.sv
`default_nettype none
package chpm_pkg;

  // ==========================================================
  // Console bus register addresses
  // ==========================================================
  localparam logic [33:0] ADDR_HALT_MASK = 34'h3_F700_0080;
  localparam logic [33:0] ADDR_HALT_SUMMARY = 34'h3_F700_0100;
  localparam logic [33:0] ADDR_SYS_RESET = 34'h3_F700_0140;
  localparam logic [33:0] ADDR_MISC = 34'h3_F700_0180;
  localparam logic [33:0] ADDR_DISCONNECT = 34'h3_F780_0000;
  localparam logic [33:0] ADDR_TAG_ACCESS = 34'h3_F780_0100;

  // ==========================================================
  // Halt summary field positions
  // ==========================================================
  localparam int HS_CONS_HALT = 6;
  localparam int HS_PWR_B_OK = 5;
  localparam int HS_PWR_A_OK = 4;
  localparam int HS_DISK_OK = 3;
  localparam int HS_SECURE = 2;
  localparam int HS_NODE_HALT = 1;

  // ==========================================================
  // Halt mask fields and reset value
  // ==========================================================
  localparam int HM_CONS_EN = 3;
  localparam int HM_SEL_LO = 1;
  localparam int HM_GLOBAL_EN = 0;
  localparam logic [7:0] HM_RESET = 8'hFF;
  localparam logic [1:0] SEL_LOOPBACK = 2'h3;

  // ==========================================================
  // Miscellaneous control fields and reset values
  // ==========================================================
  localparam int MISC_FAULT = 2;
  localparam logic [4:0] MISC_RSVD = 5'h1F;
  localparam logic MISC_FAULT_RESET = 1'b1;
  localparam logic [1:0] EXP_MAIN = 2'h0;
  localparam logic [1:0] EXP_RIGHT = 2'h1;
  localparam logic [1:0] EXP_LEFT = 2'h2;
  localparam logic [1:0] EXP_LOOP = 2'h3;
  localparam logic [1:0] EXP_RESET = 2'h3;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int SYS_RESET_CYCLES = 512;

  // ==========================================================
  // Console bus carriers
  // ==========================================================
  typedef struct packed {
    logic rd;
    logic wr;
    logic [33:0] addr;
    logic [7:0] wdata;
  } chpm_req_s;

  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } chpm_rsp_s;

endpackage
`default_nettype wire

// >>> verilog/chpm_regs.sv
`timescale 1ns/1ps
`default_nettype none
module chpm_regs
  import chpm_pkg::*;
#(
  parameter int RST_CYCLES = SYS_RESET_CYCLES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Console bus
  input wire chpm_pkg::chpm_req_s bus_req,
  output chpm_pkg::chpm_rsp_s bus_rsp,
  // Halt sources
  input wire logic [3:0] halt_char_seen,
  input wire logic node_halt_bit,
  output logic halt_req,
  output logic terminal_loopback,
  // Backplane and power status pins
  input wire logic second_power_module_good,
  input wire logic first_power_module_good,
  input wire logic disk_converter_power_good,
  input wire logic secure_key_l,
  // System bus controls
  input wire logic sys_cyc_en,
  output logic sys_reset_out,
  output logic fault_drive,
  output logic force_ignore_set,
  // Power-supply serial routing
  input wire logic ps_tx,
  output logic ps_rx,
  output logic [2:0] cab_tx,
  input wire logic [2:0] cab_rx,
  // Tag access port
  output logic tag_rd,
  output logic tag_wr,
  output logic [7:0] tag_wdata,
  input wire logic [7:0] tag_rdata
);
  import chpm_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [6:0] sync1_q, sync2_q;
  logic pwr_b_s, pwr_a_s, disk_s, secure_s;
  logic [2:0] cab_rx_s;

  // Two flops for each status pin and cabinet receive line; ps_tx, halt_char_seen and node_halt_bit are not synchronised
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
    end else begin
      sync1_q <= {cab_rx, ~secure_key_l, disk_converter_power_good,
                  first_power_module_good, second_power_module_good};
      sync2_q <= sync1_q;
    end
  end

  assign pwr_b_s = sync2_q[0];
  assign pwr_a_s = sync2_q[1];
  assign disk_s = sync2_q[2];
  assign secure_s = sync2_q[3];
  assign cab_rx_s = sync2_q[6:4];

  // ==========================================================
  // Register state
  // ==========================================================
  logic cons_halt_q, cons_halt_d;
  logic [7:0] mask_q, mask_d;
  logic fault_q, fault_d;
  logic [1:0] exp_q, exp_d;
  logic [9:0] rst_cnt_q, rst_cnt_d;
  logic fi_q, fi_d;
  logic ack_q, ack_d;
  logic [7:0] rdata_q, rdata_d;
  logic tag_rd_q, tag_rd_d, tag_wr_q, tag_wr_d;
  logic [7:0] tag_wdata_q, tag_wdata_d;
  logic ps_rx_q, ps_rx_d;
  logic [2:0] cab_tx_q, cab_tx_d;
  logic wr_halt, wr_mask, wr_rst, wr_misc, wr_disc, wr_tag, rd_tag;
  logic char_hit;
  logic [7:0] summary;

  // Address decode of the console bus
  assign wr_halt = bus_req.wr && (bus_req.addr == ADDR_HALT_SUMMARY);
  assign wr_mask = bus_req.wr && (bus_req.addr == ADDR_HALT_MASK);
  assign wr_rst = bus_req.wr && (bus_req.addr == ADDR_SYS_RESET);
  assign wr_misc = bus_req.wr && (bus_req.addr == ADDR_MISC);
  assign wr_disc = bus_req.wr && (bus_req.addr == ADDR_DISCONNECT);
  assign wr_tag = bus_req.wr && (bus_req.addr == ADDR_TAG_ACCESS);
  assign rd_tag = bus_req.rd && (bus_req.addr == ADDR_TAG_ACCESS);

  // Halt character seen on the port that the select field names
  assign char_hit = halt_char_seen[mask_q[HM_SEL_LO +: 2]];

  // Halt summary view, reserved bits zero
  assign summary = {1'b0, cons_halt_q, pwr_b_s, pwr_a_s, disk_s,
                    secure_s, node_halt_bit, 1'b0};

  // Next values of every register
  always_comb begin
    cons_halt_d = cons_halt_q;
    if (wr_halt && bus_req.wdata[HS_CONS_HALT]) begin
      cons_halt_d = 1'b0;
    end
    if (char_hit) begin
      cons_halt_d = 1'b1;
    end
    mask_d = wr_mask ? bus_req.wdata : mask_q;
    fault_d = wr_misc ? bus_req.wdata[MISC_FAULT] : fault_q;
    exp_d = wr_misc ? bus_req.wdata[1:0] : exp_q;
    rst_cnt_d = rst_cnt_q;
    if (wr_rst) begin
      rst_cnt_d = 10'(RST_CYCLES);
    end else if (sys_cyc_en && rst_cnt_q != 10'h000) begin
      rst_cnt_d = rst_cnt_q - 10'h001;
    end
    fi_d = wr_disc;
    ack_d = bus_req.rd || bus_req.wr;
    rdata_d = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ADDR_HALT_SUMMARY: rdata_d = summary;
        ADDR_HALT_MASK: rdata_d = mask_q;
        ADDR_MISC: rdata_d = {MISC_RSVD, fault_q, exp_q};
        ADDR_TAG_ACCESS: rdata_d = tag_rdata;
        default: rdata_d = 8'h00;
      endcase
    end
    tag_rd_d = rd_tag;
    tag_wr_d = wr_tag;
    tag_wdata_d = wr_tag ? bus_req.wdata : tag_wdata_q;
    cab_tx_d = 3'h0;
    ps_rx_d = 1'b0;
    unique case (exp_q)
      EXP_MAIN: begin
        cab_tx_d[0] = ps_tx;
        ps_rx_d = cab_rx_s[0];
      end
      EXP_RIGHT: begin
        cab_tx_d[1] = ps_tx;
        ps_rx_d = cab_rx_s[1];
      end
      EXP_LEFT: begin
        cab_tx_d[2] = ps_tx;
        ps_rx_d = cab_rx_s[2];
      end
      EXP_LOOP: ps_rx_d = ps_tx;
    endcase
  end

  // Register everything
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cons_halt_q <= 1'b0;
      mask_q <= HM_RESET;
      fault_q <= MISC_FAULT_RESET;
      exp_q <= EXP_RESET;
      rst_cnt_q <= 10'h000;
      fi_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
      tag_rd_q <= 1'b0;
      tag_wr_q <= 1'b0;
      tag_wdata_q <= 8'h00;
      ps_rx_q <= 1'b0;
      cab_tx_q <= 3'h0;
    end else begin
      cons_halt_q <= cons_halt_d;
      mask_q <= mask_d;
      fault_q <= fault_d;
      exp_q <= exp_d;
      rst_cnt_q <= rst_cnt_d;
      fi_q <= fi_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
      tag_rd_q <= tag_rd_d;
      tag_wr_q <= tag_wr_d;
      tag_wdata_q <= tag_wdata_d;
      ps_rx_q <= ps_rx_d;
      cab_tx_q <= cab_tx_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Fault line touches nothing but the backplane driver
  assign fault_drive = fault_q;
  assign sys_reset_out = (rst_cnt_q != 10'h000);
  assign force_ignore_set = fi_q;
  assign halt_req = mask_q[HM_GLOBAL_EN] && (node_halt_bit ||
                    (mask_q[HM_CONS_EN] && !secure_s && cons_halt_q));
  assign terminal_loopback = (mask_q[HM_SEL_LO +: 2] == SEL_LOOPBACK);
  assign bus_rsp.ack = ack_q;
  assign bus_rsp.rdata = rdata_q;
  assign tag_rd = tag_rd_q;
  assign tag_wr = tag_wr_q;
  assign tag_wdata = tag_wdata_q;
  assign ps_rx = ps_rx_q;
  assign cab_tx = cab_tx_q;

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_flag_set;
    @(posedge core_clk) disable iff (!rst_n)
    char_hit |=> cons_halt_q;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("halt flag not set");

  property p_flag_clear;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_halt && bus_req.wdata[HS_CONS_HALT] && !char_hit) |=> !cons_halt_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("halt flag not cleared");

  property p_pwr_b;
    @(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == ADDR_HALT_SUMMARY) |=> rdata_q[HS_PWR_B_OK] == $past(pwr_b_s);
  endproperty
  a_pwr_b: assert property (p_pwr_b) else $error("power b bit wrong");

  property p_disk;
    @(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == ADDR_HALT_SUMMARY) |=> rdata_q[HS_DISK_OK] == $past(disk_s);
  endproperty
  a_disk: assert property (p_disk) else $error("disk converter bit wrong");

  property p_secure;
    @(posedge core_clk) disable iff (!rst_n)
    (bus_req.rd && bus_req.addr == ADDR_HALT_SUMMARY) |=> rdata_q[HS_SECURE] == $past(secure_s);
  endproperty
  a_secure: assert property (p_secure) else $error("secure bit wrong");

  property p_reset_len;
    @(posedge core_clk) disable iff (!rst_n)
    wr_rst |=> sys_reset_out && rst_cnt_q == 10'(RST_CYCLES);
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("reset pulse not loaded");

  property p_fault;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_misc && !bus_req.wdata[MISC_FAULT]) |=> !fault_drive;
  endproperty
  a_fault: assert property (p_fault) else $error("fault drive not cleared");

  property p_loop;
    @(posedge core_clk) disable iff (!rst_n)
    (exp_q == EXP_LOOP) |=> ps_rx == $past(ps_tx);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback broken");

  property p_disc;
    @(posedge core_clk) disable iff (!rst_n)
    (wr_disc ##1 !wr_disc) |-> force_ignore_set ##1 !force_ignore_set;
  endproperty
  a_disc: assert property (p_disc) else $error("force ignore pulse wrong");

  property p_gate;
    @(posedge core_clk) disable iff (!rst_n)
    !mask_q[HM_GLOBAL_EN] |-> !halt_req;
  endproperty
  a_gate: assert property (p_gate) else $error("halt passed while disabled");

endmodule
`default_nettype wire

// >>> sim/chpm_far.sv
`timescale 1ns/1ps
`default_nettype none
module chpm_far #(
  parameter logic [7:0] TAG_INIT = 8'h5A
) (
  // Clock
  input wire logic core_clk,
  // Tag logic side
  input wire logic tag_rd,
  input wire logic tag_wr,
  input wire logic [7:0] tag_wdata,
  output logic [7:0] tag_rdata,
  // Cabinet serial lines
  input wire logic [2:0] cab_tx,
  output logic [2:0] cab_rx
);
  logic [7:0] tag_q = TAG_INIT;
  // Tag store written by strobe, read back live
  always_ff @(posedge core_clk) begin
    if (tag_wr) tag_q <= tag_wdata;
  end
  assign tag_rdata = tag_q;
  // Cabinets answer with the inverse so loopback is told apart
  assign cab_rx = ~cab_tx;
endmodule
`default_nettype wire

// >>> sim/tb_console_halt_power_misc_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_console_halt_power_misc_regs;
  import chpm_pkg::*;
  localparam int RC = 8;
  logic core_clk = 0, rst_n = 0, nh = 0, pb = 1, pa = 0, dk = 1, sk = 1, cyc = 0, ps_tx = 0;
  logic halt_req, tl, sro, fd, fis, ps_rx, trd, twr;
  logic [3:0] hcs = '0;
  logic [2:0] cab_tx, cab_rx;
  logic [7:0] twd, trdat;
  logic [8:0] e;
  logic [8:0] exp_q[$];
  logic [15:0] lf = 16'h0002;
  chpm_req_s bus_req = '0;
  chpm_rsp_s bus_rsp;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  // ==========================================================
  // Clock and instances
  // ==========================================================
  initial forever #2 core_clk = ~core_clk;
  chpm_regs #(.RST_CYCLES(RC)) chpm_regs_i (.core_clk(core_clk), .rst_n(rst_n), .bus_req(bus_req),
    .bus_rsp(bus_rsp), .halt_char_seen(hcs), .node_halt_bit(nh), .halt_req(halt_req),
    .terminal_loopback(tl), .second_power_module_good(pb), .first_power_module_good(pa),
    .disk_converter_power_good(dk), .secure_key_l(sk), .sys_cyc_en(cyc), .sys_reset_out(sro),
    .fault_drive(fd), .force_ignore_set(fis), .ps_tx(ps_tx), .ps_rx(ps_rx), .cab_tx(cab_tx),
    .cab_rx(cab_rx), .tag_rd(trd), .tag_wr(twr), .tag_wdata(twd), .tag_rdata(trdat));
  chpm_far chpm_far_i (.core_clk(core_clk), .tag_rd(trd), .tag_wr(twr), .tag_wdata(twd),
    .tag_rdata(trdat), .cab_tx(cab_tx), .cab_rx(cab_rx));
  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] ex, logic [7:0] g);
    samples_checked++;
    if (g !== ex) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, ex, g);
    end
  endtask
  // One console access; reads note their expected data
  task automatic acc(logic r, logic w, logic [33:0] a, logic [7:0] wd, logic [8:0] ex);
    @(posedge core_clk);
    bus_req <= '{rd: r, wr: w, addr: a, wdata: wd};
    exp_q.push_back(ex);
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    bus_req.wr <= 1'b0;
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge core_clk);
  endtask
  function automatic logic [8:0] summ(logic f);
    return {2'b10, f, pb, pa, dk, ~sk, nh, 1'b0};
  endfunction
  // Next state of the stimulus shift register
  function automatic logic [15:0] lfsr_next(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Monitor pairs each ack with the oldest note
  always @(posedge core_clk) begin
    if (bus_rsp.ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[FAIL] ack expected 0 seen 1");
      end else begin
        e = exp_q.pop_front();
        if (e[8]) chk("rdata", e[7:0], bus_rsp.rdata);
      end
    end
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      $display("[FAIL] cycles expected below %0d seen %0d", 4000, cycles);
      complete_run();
    end
  end
  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    wt(5);
    rst_n <= 1'b1;
    wt(4);
    acc(1'b1, 1'b0, ADDR_MISC, 8'h00, 9'h1FF);
    acc(1'b1, 1'b0, ADDR_HALT_MASK, 8'h00, {1'b1, HM_RESET});
    chk("fault_drive", 8'h01, 8'(fd));
    chk("loopback", 8'h01, 8'(tl));
    acc(1'b1, 1'b0, ADDR_HALT_SUMMARY, 8'h00, summ(1'b0));
    acc(1'b0, 1'b1, ADDR_HALT_SUMMARY, 8'hBF, 9'h000);
    acc(1'b1, 1'b0, ADDR_HALT_SUMMARY, 8'h00, summ(1'b0));
    pb <= 1'b0;
    pa <= 1'b1;
    dk <= 1'b0;
    sk <= 1'b0;
    nh <= 1'b1;
    wt(4);
    acc(1'b1, 1'b0, ADDR_HALT_SUMMARY, 8'h00, summ(1'b0));
    chk("halt_req", 8'h01, 8'(halt_req));
    nh <= 1'b0;
    sk <= 1'b1;
    acc(1'b0, 1'b1, ADDR_HALT_MASK, 8'hF9, 9'h000);
    hcs <= 4'h8;
    wt(1);
    hcs <= 4'h0;
    wt(2);
    acc(1'b1, 1'b0, ADDR_HALT_SUMMARY, 8'h00, summ(1'b0));
    hcs <= 4'h1;
    wt(1);
    hcs <= 4'h0;
    wt(2);
    acc(1'b1, 1'b0, ADDR_HALT_SUMMARY, 8'h00, summ(1'b1));
    chk("halt_req", 8'h01, 8'(halt_req));
    acc(1'b0, 1'b1, ADDR_HALT_MASK, 8'hFE, 9'h000);
    #1;
    chk("halt_req", 8'h00, 8'(halt_req));
    acc(1'b0, 1'b1, ADDR_HALT_MASK, 8'hFF, 9'h000);
    sk <= 1'b0;
    wt(4);
    chk("halt_req", 8'h00, 8'(halt_req));
    sk <= 1'b1;
    acc(1'b0, 1'b1, ADDR_HALT_SUMMARY, 8'h40, 9'h000);
    acc(1'b1, 1'b0, ADDR_HALT_SUMMARY, 8'h00, summ(1'b0));
    // Select code 11 watches the looped port
    hcs <= 4'h8;
    wt(1);
    hcs <= 4'h0;
    wt(2);
    acc(1'b1, 1'b0, ADDR_HALT_SUMMARY, 8'h00, summ(1'b1));
    acc(1'b0, 1'b1, ADDR_HALT_SUMMARY, 8'h40, 9'h000);
    acc(1'b0, 1'b1, ADDR_SYS_RESET, 8'h3C, 9'h000);
    repeat (RC - 1) begin
      @(posedge core_clk) cyc <= 1'b1;
      @(posedge core_clk) cyc <= 1'b0;
    end
    #1;
    chk("sys_reset", 8'h01, 8'(sro));
    @(posedge core_clk) cyc <= 1'b1;
    @(posedge core_clk) cyc <= 1'b0;
    wt(2);
    chk("sys_reset", 8'h00, 8'(sro));
    acc(1'b0, 1'b1, ADDR_MISC, 8'h00, 9'h000);
    acc(1'b1, 1'b0, ADDR_MISC, 8'h00, 9'h1F8);
    // The fault line itself is watched, not the register bit
    chk("fault_drive", 8'h00, 8'(fd));
    for (int c = 0; c < 4; c++) begin
      acc(1'b0, 1'b1, ADDR_MISC, 8'(c), 9'h000);
      ps_tx <= 1'b1;
      wt(6);
      chk("ps_rx", (c == 3) ? 8'h01 : 8'h00, 8'(ps_rx));
      if (c < 3) chk("cab_tx", 8'h01, 8'(cab_tx[c]));
      ps_tx <= 1'b0;
      wt(6);
      chk("ps_rx", (c == 3) ? 8'h00 : 8'h01, 8'(ps_rx));
    end
    // Software falls back here once its diagnostic register write has failed
    acc(1'b0, 1'b1, ADDR_DISCONNECT, 8'h00, 9'h000);
    #1;
    chk("force_ignore", 8'h01, 8'(fis));
    wt(1);
    #1;
    chk("force_ignore", 8'h00, 8'(fis));
    acc(1'b1, 1'b0, ADDR_DISCONNECT, 8'h00, 9'h100);
    acc(1'b1, 1'b0, 34'h3_F700_0040, 8'h00, 9'h100);
    acc(1'b0, 1'b1, ADDR_TAG_ACCESS, 8'hC3, 9'h000);
    wt(2);
    acc(1'b1, 1'b0, ADDR_TAG_ACCESS, 8'h00, 9'h1C3);
    #1;
    chk("tag_rd", 8'h01, 8'(trd));
    repeat (4) begin
      lf = lfsr_next(lf);
      acc(1'b0, 1'b1, ADDR_HALT_MASK, lf[7:0], 9'h000);
      acc(1'b1, 1'b0, ADDR_HALT_MASK, 8'h00, {1'b1, lf[7:0]});
    end
    // Reset in mid-count: pulse and settings return to their reset values
    acc(1'b0, 1'b1, ADDR_SYS_RESET, 8'h00, 9'h000);
    wt(1);
    rst_n <= 1'b0;
    wt(2);
    chk("sys_reset", 8'h00, 8'(sro));
    chk("fault_drive", 8'h01, 8'(fd));
    chk("loopback", 8'h01, 8'(tl));
    rst_n <= 1'b1;
    wt(1);
    acc(1'b1, 1'b0, ADDR_MISC, 8'h00, 9'h1FF);
    acc(1'b1, 1'b0, ADDR_HALT_MASK, 8'h00, {1'b1, HM_RESET});
    wt(3);
    // Every access must have been answered
    chk("pending", 8'h00, 8'(exp_q.size()));
    complete_run();
  end
endmodule
`default_nettype wire
